/* hw/pmr_pkg.sv */
// shared constants and types for the power-mode, reset and strobe control
package pmr_pkg;
	// ------------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ------------------------------------------------------------------
	localparam logic [11:0] IDX_AUX_CTRL   = 12'h08e; // auxiliary control
	localparam logic [11:0] IDX_PWR_CTRL   = 12'h087; // power control
	localparam logic [11:0] IDX_WAKE_EN    = 12'h080; // wake-up enables
	localparam logic [11:0] IDX_STATUS     = 12'h081; // mode and reset state
	localparam logic [11:0] IDX_PORT_LATCH = 12'h082; // port latch image
	localparam logic [11:0] IDX_STACK_PTR  = 12'h083; // stack pointer image
	localparam logic [11:0] IDX_SER_BUF    = 12'h084; // serial data buffer

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int IDLE_BIT     = 0; // idle request bit
	localparam int PDOWN_BIT    = 1; // power-down request bit
	localparam int KEEP_BIT     = 4; // power control bit kept over reset
	localparam int SUPPRESS_BIT = 0; // strobe suppress bit

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] PORT_RST  = 8'hff;
	localparam logic [7:0] SP_RST    = 8'h07;
	localparam logic [7:0] SFR_RST   = 8'h00;
	localparam logic [7:0] KEEP_MASK = 8'h10; // bit of power control kept

	// ------------------------------------------------------------------
	// timing: oscillator edges per machine cycle and sampling point
	// ------------------------------------------------------------------
	localparam int         OSC_PER_PHASE  = 2;  // clock divided by two
	localparam int         PHASES_PER_MC  = 12; // six states, two phases
	localparam logic [3:0] STATE_FIVE_PHASE_TWO_PHASE     = 4'h9; // state five, phase two
	localparam logic [3:0] LAST_PHASE     = 4'hb;
	localparam int         RST_MIN_MC     = 2;  // machine cycles held high

	// ------------------------------------------------------------------
	// bus answers
	// ------------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_RUN   = 2'b00,
		MODE_IDLE  = 2'b01,
		MODE_PDOWN = 2'b11
	} pwr_mode_t;

	typedef struct packed {
		logic cpu;    // processor core clock
		logic periph; // peripheral and interrupt logic clock
		logic osc;    // oscillator running
	} clk_en_t;
endpackage

/* hw/sync2.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             ce,
	// data
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_ff; // first stage, read only by second stage
	logic [WIDTH-1:0] sync_ff; // second stage
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_sync;

	// ------------------------------------------------------------------
	// next values
	// ------------------------------------------------------------------
	always_comb begin
		nxt_meta = din;
		nxt_sync = meta_ff;
	end

	// registers; clock enable freezes both stages
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else if (ce) begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign dout = sync_ff;
endmodule
`default_nettype wire

/* hw/reset_filter.sv */
// deglitch filter for the sampled external reset level
`timescale 1ns/1ps
`default_nettype none
module reset_filter #(
	parameter int MIN_SAMPLES = pmr_pkg::RST_MIN_MC
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	// sampling
	input  wire logic sample_stb, // one pulse per machine cycle
	input  wire logic level,      // synchronised reset pin
	output logic      rst_active
);
	logic [3:0] cnt_ff;  // consecutive high samples
	logic       act_ff;  // filtered reset
	logic [3:0] nxt_cnt;
	logic       nxt_act;

	// ------------------------------------------------------------------
	// count consecutive high samples; one low sample clears
	// ------------------------------------------------------------------
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_act = act_ff;
		if (sample_stb) begin
			if (!level) begin
				// a short pulse never reaches the count
				nxt_cnt = 4'h0;
				nxt_act = 1'b0;
			end else if (cnt_ff < 4'(MIN_SAMPLES)) begin
				nxt_cnt = cnt_ff + 4'h1;
				nxt_act = (cnt_ff + 4'h1) >= 4'(MIN_SAMPLES);
			end
		end
	end

	// registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff <= 4'h0;
			act_ff <= 1'b0;
		end else if (ce) begin
			cnt_ff <= nxt_cnt;
			act_ff <= nxt_act;
		end
	end

	assign rst_active = act_ff;
endmodule
`default_nettype wire

/* hw/power_mode_reset_ale_control.sv */
// power-mode, device reset and address strobe control with axi4-lite regs
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module power_mode_reset_ale_control #(
	parameter int WAKE_LINES = 8
) (
	// clock, reset, enable
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  ce,
	// axi4-lite write address and data
	input  wire logic                  s_awvalid,
	output logic                       s_awready,
	input  wire logic [13:0]           s_awaddr,
	input  wire logic                  s_wvalid,
	output logic                       s_wready,
	input  wire logic [31:0]           s_wdata,
	input  wire logic [3:0]            s_wstrb,
	// axi4-lite write response
	output logic                       s_bvalid,
	input  wire logic                  s_bready,
	output logic [1:0]                 s_bresp,
	// axi4-lite read
	input  wire logic                  s_arvalid,
	output logic                       s_arready,
	input  wire logic [13:0]           s_araddr,
	output logic                       s_rvalid,
	input  wire logic                  s_rready,
	output logic [31:0]                s_rdata,
	output logic [1:0]                 s_rresp,
	// pins
	input  wire logic                  rst_pin,
	input  wire logic [WAKE_LINES-1:0] wakeup_interrupt_lines,
	// core side
	input  wire logic                  irq_taken,
	input  wire logic                  ext_access,
	input  wire logic                  ale_core,
	// outputs
	output logic                       ale_out,
	output pmr_pkg::clk_en_t           clk_en,
	output logic                       phase_clk,
	output logic                       core_reset,
	output logic [7:0]                 port_latch,
	output logic [7:0]                 stack_ptr
);
	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	pmr_pkg::pwr_mode_t    mode_ff, nxt_mode;   // power mode
	logic [7:0]            power_control_register_ff, nxt_power_control_register;   // power control register
	logic [7:0]            aux_ff, nxt_aux;     // auxiliary control register
	logic [7:0]            wen_ff, nxt_wen;     // wake-up enables
	logic [7:0]            port_ff, nxt_port;   // port latch image
	logic [7:0]            sp_ff, nxt_sp;       // stack pointer image
	logic [7:0]            serial_data_buffer_ff, nxt_serial_data_buffer;   // serial data buffer
	logic [3:0]            phase_ff, nxt_phase; // phase within machine cycle
	logic                  div_ff, nxt_div;     // divide-by-two toggle
	logic                  ale_ff, nxt_ale;     // registered strobe
	logic                  aw_ff, nxt_aw;       // write address held
	logic                  w_ff, nxt_w;         // write data held
	logic [11:0]           awi_ff, nxt_awi;     // write index
	logic [31:0]           wd_ff, nxt_wd;       // write data
	logic                  wb0_ff, nxt_wb0;     // low byte lane strobe
	logic                  bv_ff, nxt_bv;       // write response valid
	logic [1:0]            br_ff, nxt_br;       // write response code
	logic                  rv_ff, nxt_rv;       // read data valid
	logic [31:0]           rd_ff, nxt_rd;       // read data
	logic [1:0]            rr_ff, nxt_rr;       // read response code

	// ------------------------------------------------------------------
	// pin synchronisers and reset filter
	// ------------------------------------------------------------------
	logic                  rst_sync;            // reset pin, synchronised
	logic [WAKE_LINES-1:0] wake_sync;           // wake-up lines, synchronised
	logic                  state_five_phase_two_stb;            // sampling point strobe
	logic                  dev_rst;             // filtered device reset
	logic                  wake_hit;            // enabled wake-up line active
	logic                  wr_do;               // write performed now

	sync2 #(.WIDTH(1)) u_rst_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.din     (rst_pin),
		.dout    (rst_sync)
	);

	sync2 #(.WIDTH(WAKE_LINES)) u_wake_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.din     (wakeup_interrupt_lines),
		.dout    (wake_sync)
	);

	reset_filter #(.MIN_SAMPLES(pmr_pkg::RST_MIN_MC)) u_rst_filter (
		.aclk       (aclk),
		.aresetn    (aresetn),
		.ce         (ce),
		.sample_stb (state_five_phase_two_stb),
		.level      (rst_sync),
		.rst_active (dev_rst)
	);

	// index decode shared by read and write paths
	function automatic logic is_mapped(input logic [11:0] idx);
		is_mapped = (idx == pmr_pkg::IDX_AUX_CTRL) ||
			(idx == pmr_pkg::IDX_PWR_CTRL) ||
			(idx == pmr_pkg::IDX_WAKE_EN) ||
			(idx == pmr_pkg::IDX_STATUS) ||
			(idx == pmr_pkg::IDX_PORT_LATCH) ||
			(idx == pmr_pkg::IDX_STACK_PTR) ||
			(idx == pmr_pkg::IDX_SER_BUF);
	endfunction

	// ------------------------------------------------------------------
	// machine cycle timing
	// ------------------------------------------------------------------
	// sampling strobe once per machine cycle, only while oscillator runs
	assign state_five_phase_two_stb = clk_en.osc && div_ff &&
		(phase_ff == pmr_pkg::STATE_FIVE_PHASE_TWO_PHASE);
	assign wake_hit = |(wake_sync & wen_ff[WAKE_LINES-1:0]);

	always_comb begin
		nxt_div   = div_ff;
		nxt_phase = phase_ff;
		// oscillator halted: the divider and phase counter stand still
		if (clk_en.osc) begin
			nxt_div = !div_ff;
			if (div_ff) begin
				nxt_phase = (phase_ff == pmr_pkg::LAST_PHASE) ?
					4'h0 : phase_ff + 4'h1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_ff   <= 1'b0;
			phase_ff <= 4'h0;
		end else if (ce) begin
			div_ff   <= nxt_div;
			phase_ff <= nxt_phase;
		end
	end

	// ------------------------------------------------------------------
	// power mode machine
	// ------------------------------------------------------------------
	always_comb begin
		nxt_mode = mode_ff;
		unique case (mode_ff)
			pmr_pkg::MODE_RUN: begin
				if (power_control_register_ff[pmr_pkg::PDOWN_BIT])
					nxt_mode = pmr_pkg::MODE_PDOWN;
				else if (power_control_register_ff[pmr_pkg::IDLE_BIT])
					nxt_mode = pmr_pkg::MODE_IDLE;
			end
			pmr_pkg::MODE_IDLE: begin
				// interrupt logic keeps running and can end idle
				if (irq_taken || dev_rst)
					nxt_mode = pmr_pkg::MODE_RUN;
			end
			pmr_pkg::MODE_PDOWN: begin
				// filter cannot sample with oscillator stopped, so the
				// synchronised pin level restarts the oscillator
				if (rst_sync || wake_hit)
					nxt_mode = pmr_pkg::MODE_RUN;
			end
			default: nxt_mode = pmr_pkg::MODE_RUN;
		endcase
		if (dev_rst)
			nxt_mode = pmr_pkg::MODE_RUN;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			mode_ff <= pmr_pkg::MODE_RUN;
		else if (ce)
			mode_ff <= nxt_mode;
	end

	// clock enables derived from the mode
	always_comb begin
		clk_en.cpu    = (mode_ff == pmr_pkg::MODE_RUN);
		clk_en.periph = (mode_ff != pmr_pkg::MODE_PDOWN);
		clk_en.osc    = (mode_ff != pmr_pkg::MODE_PDOWN);
	end

	// ------------------------------------------------------------------
	// address strobe
	// ------------------------------------------------------------------
	always_comb begin
		if (aux_ff[pmr_pkg::SUPPRESS_BIT] && !ext_access)
			nxt_ale = 1'b0;
		else
			nxt_ale = ale_core;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			ale_ff <= 1'b0;
		else if (ce)
			ale_ff <= nxt_ale;
	end

	// ------------------------------------------------------------------
	// bus slave and register file
	// ------------------------------------------------------------------
	assign wr_do = aw_ff && w_ff && !bv_ff;

	always_comb begin
		nxt_aw   = aw_ff;
		nxt_w    = w_ff;
		nxt_awi  = awi_ff;
		nxt_wd   = wd_ff;
		nxt_wb0  = wb0_ff;
		nxt_bv   = bv_ff;
		nxt_br   = br_ff;
		nxt_rv   = rv_ff;
		nxt_rd   = rd_ff;
		nxt_rr   = rr_ff;
		nxt_power_control_register = power_control_register_ff;
		nxt_aux  = aux_ff;
		nxt_wen  = wen_ff;
		nxt_port = port_ff;
		nxt_sp   = sp_ff;
		nxt_serial_data_buffer = serial_data_buffer_ff;
		// address and data taken independently, in either order
		if (s_awvalid && !aw_ff) begin
			nxt_aw  = 1'b1;
			nxt_awi = s_awaddr[13:2];
		end
		if (s_wvalid && !w_ff) begin
			nxt_w   = 1'b1;
			nxt_wd  = s_wdata;
			nxt_wb0 = s_wstrb[0];
		end
		if (wr_do) begin
			nxt_aw = 1'b0;
			nxt_w  = 1'b0;
			nxt_bv = 1'b1;
			nxt_br = is_mapped(awi_ff) ?
				pmr_pkg::RESP_OKAY : pmr_pkg::RESP_SLVERR;
			// only the low byte lane carries register data
			if (wb0_ff) begin
				unique case (awi_ff)
					pmr_pkg::IDX_PWR_CTRL:   nxt_power_control_register = wd_ff[7:0];
					pmr_pkg::IDX_AUX_CTRL:   nxt_aux  = wd_ff[7:0];
					pmr_pkg::IDX_WAKE_EN:    nxt_wen  = wd_ff[7:0];
					pmr_pkg::IDX_PORT_LATCH: nxt_port = wd_ff[7:0];
					pmr_pkg::IDX_STACK_PTR:  nxt_sp   = wd_ff[7:0];
					pmr_pkg::IDX_SER_BUF:    nxt_serial_data_buffer = wd_ff[7:0];
					default: ;
				endcase
			end
		end
		if (bv_ff && s_bready)
			nxt_bv = 1'b0;
		// hardware exit clears the request bits after a software write
		if (mode_ff == pmr_pkg::MODE_IDLE && irq_taken)
			nxt_power_control_register[pmr_pkg::IDLE_BIT] = 1'b0;
		if (mode_ff == pmr_pkg::MODE_PDOWN && wake_hit)
			nxt_power_control_register[pmr_pkg::PDOWN_BIT] = 1'b0;
		// device reset loads fixed values except the kept power control bit, serial buffer untouched
		if (dev_rst || (mode_ff == pmr_pkg::MODE_PDOWN && rst_sync)) begin
			nxt_port = pmr_pkg::PORT_RST;
			nxt_sp   = pmr_pkg::SP_RST;
			nxt_power_control_register = (power_control_register_ff & pmr_pkg::KEEP_MASK) |
				(pmr_pkg::SFR_RST & ~pmr_pkg::KEEP_MASK);
			nxt_aux  = pmr_pkg::SFR_RST;
			nxt_wen  = pmr_pkg::SFR_RST;
		end
		// reads answer one cycle after the address is taken
		if (s_arvalid && !rv_ff) begin
			nxt_rv = 1'b1;
			nxt_rr = is_mapped(s_araddr[13:2]) ?
				pmr_pkg::RESP_OKAY : pmr_pkg::RESP_SLVERR;
			unique case (s_araddr[13:2])
				pmr_pkg::IDX_PWR_CTRL:   nxt_rd = {24'h0, power_control_register_ff};
				pmr_pkg::IDX_AUX_CTRL:   nxt_rd = {24'h0, aux_ff};
				pmr_pkg::IDX_WAKE_EN:    nxt_rd = {24'h0, wen_ff};
				pmr_pkg::IDX_STATUS:     nxt_rd = {28'h0, clk_en.osc,
					dev_rst, mode_ff};
				pmr_pkg::IDX_PORT_LATCH: nxt_rd = {24'h0, port_ff};
				pmr_pkg::IDX_STACK_PTR:  nxt_rd = {24'h0, sp_ff};
				pmr_pkg::IDX_SER_BUF:    nxt_rd = {24'h0, serial_data_buffer_ff};
				default:                 nxt_rd = 32'h0;
			endcase
		end else if (rv_ff && s_rready) begin
			nxt_rv = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff   <= 1'b0;
			w_ff    <= 1'b0;
			awi_ff  <= 12'h0;
			wd_ff   <= 32'h0;
			wb0_ff  <= 1'b0;
			bv_ff   <= 1'b0;
			br_ff   <= pmr_pkg::RESP_OKAY;
			rv_ff   <= 1'b0;
			rd_ff   <= 32'h0;
			rr_ff   <= pmr_pkg::RESP_OKAY;
			power_control_register_ff <= pmr_pkg::SFR_RST;
			aux_ff  <= pmr_pkg::SFR_RST;
			wen_ff  <= pmr_pkg::SFR_RST;
			port_ff <= pmr_pkg::PORT_RST;
			sp_ff   <= pmr_pkg::SP_RST;
			serial_data_buffer_ff <= pmr_pkg::SFR_RST;
		end else if (ce) begin
			aw_ff   <= nxt_aw;
			w_ff    <= nxt_w;
			awi_ff  <= nxt_awi;
			wd_ff   <= nxt_wd;
			wb0_ff  <= nxt_wb0;
			bv_ff   <= nxt_bv;
			br_ff   <= nxt_br;
			rv_ff   <= nxt_rv;
			rd_ff   <= nxt_rd;
			rr_ff   <= nxt_rr;
			power_control_register_ff <= nxt_power_control_register;
			aux_ff  <= nxt_aux;
			wen_ff  <= nxt_wen;
			port_ff <= nxt_port;
			sp_ff   <= nxt_sp;
			serial_data_buffer_ff <= nxt_serial_data_buffer;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign s_awready  = !aw_ff;
	assign s_wready   = !w_ff;
	assign s_bvalid   = bv_ff;
	assign s_bresp    = br_ff;
	assign s_arready  = !rv_ff;
	assign s_rvalid   = rv_ff;
	assign s_rdata    = rd_ff;
	assign s_rresp    = rr_ff;
	assign ale_out    = ale_ff;
	assign phase_clk  = div_ff;
	assign core_reset = dev_rst;
	assign port_latch = port_ff;
	assign stack_ptr  = sp_ff;
endmodule
`default_nettype wire

/* testbench/pmr_assertions.sv */
// concurrent checks on the power-mode, reset and strobe control ports
`timescale 1ns/1ps
`default_nettype none
module pmr_assertions (
	// clock and reset
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic             ce,
	// register bus handshakes
	input wire logic             s_awvalid,
	input wire logic             s_awready,
	input wire logic             s_wvalid,
	input wire logic             s_wready,
	input wire logic             s_bvalid,
	input wire logic             s_arvalid,
	input wire logic             s_arready,
	input wire logic             s_rvalid,
	// pins and core side
	input wire logic             rst_pin,
	input wire logic             irq_taken,
	input wire logic             ext_access,
	input wire logic             ale_core,
	// outputs watched
	input wire logic             ale_out,
	input wire pmr_pkg::clk_en_t clk_en,
	input wire logic             phase_clk,
	input wire logic             core_reset,
	input wire logic [7:0]       port_latch,
	input wire logic [7:0]       stack_ptr
);
	// ------------------------------------------------------------------
	// helper: how long the reset pin has stayed high
	// ------------------------------------------------------------------
	logic [7:0] high_cnt_ff; // saturates so long pulses never wrap
	logic [7:0] nxt_high_cnt;
	// next count, cleared by any low cycle
	always_comb begin
		nxt_high_cnt = !rst_pin ? 8'h00 :
			(&high_cnt_ff ? high_cnt_ff : high_cnt_ff + 8'h01);
	end
	// count register
	always_ff @(posedge aclk) begin
		if (!aresetn)
			high_cnt_ff <= 8'h00;
		else
			high_cnt_ff <= nxt_high_cnt;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// both write channels taken at one edge
	sequence wr_both;
		s_awvalid && s_awready && s_wvalid && s_wready;
	endsequence
	// reset held for two clocks in a row
	sequence rst_held;
		core_reset [*2];
	endsequence
	chk_phase_toggle: assert property
		(ce && clk_en.osc |=> phase_clk != $past(phase_clk))
		else $error("phase clock did not toggle");
	chk_idle_periph: assert property (clk_en.osc |-> clk_en.periph)
		else $error("peripheral clock off with oscillator on");
	chk_pdown_all: assert property
		(!clk_en.osc |-> !clk_en.cpu && !clk_en.periph)
		else $error("clock running with oscillator stopped");
	chk_idle_exit: assert property
		(ce && irq_taken && !clk_en.cpu && clk_en.osc |=> clk_en.cpu)
		else $error("interrupt did not end idle");
	chk_reset_image: assert property
		(rst_held |-> port_latch == pmr_pkg::PORT_RST
			&& stack_ptr == pmr_pkg::SP_RST)
		else $error("reset image wrong");
	chk_reset_glitch: assert property
		($rose(core_reset) |-> high_cnt_ff >= 8'h0d)
		else $error("reset taken from a short pulse");
	chk_reset_drop: assert property ($fell(rst_pin) |-> ##[1:28] !core_reset)
		else $error("reset held after pin low");
	chk_strobe_ext: assert property
		(ce && ext_access |=> ale_out == $past(ale_core))
		else $error("strobe not passed during external access");
	chk_write_answer: assert property (wr_both |-> ##2 s_bvalid)
		else $error("write response late");
	chk_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
		else $error("read data late");
endmodule
bind power_mode_reset_ale_control pmr_assertions u_pmr_assertions (
	.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_awvalid(s_awvalid),
	.s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
	.s_bvalid(s_bvalid), .s_arvalid(s_arvalid), .s_arready(s_arready),
	.s_rvalid(s_rvalid), .rst_pin(rst_pin), .irq_taken(irq_taken),
	.ext_access(ext_access), .ale_core(ale_core), .ale_out(ale_out),
	.clk_en(clk_en), .phase_clk(phase_clk), .core_reset(core_reset),
	.port_latch(port_latch), .stack_ptr(stack_ptr)
);
`default_nettype wire

/* testbench/ext_side_model.sv */
// far side: reset source, external memory activity and core strobe
`timescale 1ns/1ps
`default_nettype none
module ext_side_model (
	// clock
	input  wire logic       aclk,
	// commands from the bench
	input  wire logic       rst_go,
	input  wire logic [7:0] rst_len,
	input  wire logic       ext_req,
	// pins toward the block
	output logic            rst_pin,
	output logic            ext_access,
	output logic            ale_core
);
	logic [7:0] left_ff; // reset cycles still to drive
	initial begin
		left_ff = 8'h00;
		rst_pin = 1'b0;
		ext_access = 1'b0;
		ale_core = 1'b0;
	end
	// pin has a pull-down, so a released reset reads low
	always @(posedge aclk) begin
		left_ff <= rst_go ? rst_len : left_ff - {7'h00, left_ff != 8'h00};
		rst_pin <= (left_ff != 8'h00);
		ext_access <= ext_req;
		ale_core <= !ale_core; // strobe busy every cycle, worst for noise
	end
endmodule
`default_nettype wire

/* testbench/power_mode_reset_ale_control_bench.sv */
// self-checking bench for the power-mode, reset and strobe control
`timescale 1ns/1ps
`default_nettype none
module power_mode_reset_ale_control_bench;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	logic             aclk, aresetn, ce, s_awvalid, s_awready, s_wvalid;
	logic             s_wready, s_bvalid, s_bready, s_arvalid, s_arready;
	logic             s_rvalid, s_rready, rst_pin, irq_taken, ext_access;
	logic             ale_core, ale_out, phase_clk, core_reset, rst_go;
	logic             ext_req;
	logic [13:0]      s_awaddr, s_araddr;
	logic [31:0]      s_wdata, s_rdata;
	logic [3:0]       s_wstrb;
	logic [1:0]       s_bresp, s_rresp;
	logic [7:0]       wake, port_latch, stack_ptr, rst_len;
	pmr_pkg::clk_en_t clk_en;
	int               num_errors, samples_checked, cycles;
	power_mode_reset_ale_control u_power_mode_reset_ale_control (
		.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_awaddr(s_awaddr), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
		.s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
		.s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr),
		.s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata),
		.s_rresp(s_rresp), .rst_pin(rst_pin), .wakeup_interrupt_lines(wake),
		.irq_taken(irq_taken), .ext_access(ext_access), .ale_core(ale_core),
		.ale_out(ale_out), .clk_en(clk_en), .phase_clk(phase_clk),
		.core_reset(core_reset), .port_latch(port_latch),
		.stack_ptr(stack_ptr)
	);
	ext_side_model u_ext_side_model (
		.aclk(aclk), .rst_go(rst_go), .rst_len(rst_len), .ext_req(ext_req),
		.rst_pin(rst_pin), .ext_access(ext_access), .ale_core(ale_core)
	);
	// 100 MHz clock
	always #5 aclk = ~aclk;
	// hang guard, far above the few hundred cycles needed
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			num_errors++;
			end_of_test();
		end
	end
	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// write: address and data offered together, each dropped when taken
	task automatic wr(input logic [11:0] idx, input logic [7:0] d);
		@(posedge aclk);
		s_awaddr <= {idx, 2'b00};
		s_wdata <= {24'h000000, d};
		s_wstrb <= 4'hf;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (!s_bvalid);
		s_bready <= 1'b0;
		chk({30'h0, s_bresp}, {30'h0, pmr_pkg::RESP_OKAY});
	endtask
	// read one register and compare data and answer code
	task automatic rd_chk(input logic [11:0] idx, input logic [7:0] e,
			input logic [1:0] r);
		@(posedge aclk);
		s_araddr <= {idx, 2'b00};
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_arready) s_arvalid <= 1'b0;
		end while (!s_rvalid);
		s_rready <= 1'b0;
		chk(s_rdata, {24'h000000, e});
		chk({30'h0, s_rresp}, {30'h0, r});
	endtask
	task automatic pulse(input logic [7:0] n);
		@(posedge aclk);
		rst_len <= n;
		rst_go <= 1'b1;
		@(posedge aclk);
		rst_go <= 1'b0;
	endtask
	// bounded wait for the device reset level
	task automatic wait_rst(input logic v);
		int n;
		n = 0;
		while (core_reset !== v && n < 80) begin
			@(posedge aclk);
			n++;
		end
		chk(core_reset, v);
	endtask
	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_regs();
		rd_chk(pmr_pkg::IDX_PORT_LATCH, pmr_pkg::PORT_RST, 2'b00);
		rd_chk(pmr_pkg::IDX_STACK_PTR, pmr_pkg::SP_RST, 2'b00);
		rd_chk(pmr_pkg::IDX_PWR_CTRL, 8'h00, 2'b00);
		rd_chk(pmr_pkg::IDX_AUX_CTRL, 8'h00, 2'b00);
		rd_chk(12'h0ff, 8'h00, pmr_pkg::RESP_SLVERR);
	endtask
	// strobe frozen, released for external access, frozen again
	task automatic t_strobe();
		wr(pmr_pkg::IDX_AUX_CTRL, 8'h01);
		for (int i = 0; i < 24; i++) begin
			@(posedge aclk);
			ext_req <= (i >= 8 && i < 16);
			if ((i > 2 && i < 8) || i > 19) chk(ale_out, 1'b0);
			if (i > 11 && i < 16) chk(ale_out, !ale_core);
		end
		wr(pmr_pkg::IDX_AUX_CTRL, 8'h00);
	endtask
	task automatic t_idle();
		wr(pmr_pkg::IDX_PWR_CTRL, 8'h01);
		repeat (2) @(posedge aclk);
		chk(clk_en, 3'b011);
		rd_chk(pmr_pkg::IDX_STATUS, 8'h09, 2'b00);
		irq_taken <= 1'b1;
		@(posedge aclk);
		irq_taken <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(clk_en, 3'b111);
		rd_chk(pmr_pkg::IDX_PWR_CTRL, 8'h00, 2'b00);
	endtask
	// a disabled line must not wake, an enabled one must
	task automatic t_pdown();
		wr(pmr_pkg::IDX_WAKE_EN, 8'h01);
		wr(pmr_pkg::IDX_PWR_CTRL, 8'h02);
		wake <= 8'h02;
		repeat (8) @(posedge aclk);
		chk(clk_en, 3'b000);
		wake <= 8'h03;
		repeat (6) @(posedge aclk);
		chk(clk_en, 3'b111);
		wake <= 8'h00;
		rd_chk(pmr_pkg::IDX_PWR_CTRL, 8'h00, 2'b00);
	endtask
	task automatic t_reset();
		wr(pmr_pkg::IDX_PWR_CTRL, pmr_pkg::KEEP_MASK);
		wr(pmr_pkg::IDX_AUX_CTRL, 8'h01);
		wr(pmr_pkg::IDX_SER_BUF, 8'h5a);
		wr(pmr_pkg::IDX_PORT_LATCH, 8'h3c);
		wr(pmr_pkg::IDX_STACK_PTR, 8'h55);
		pulse(8'h06);
		repeat (40) @(posedge aclk);
		chk(core_reset, 1'b0);
		pulse(8'h34);
		wait_rst(1'b1);
		// image is loaded at the edge after the reset level appears
		@(posedge aclk);
		chk(port_latch, pmr_pkg::PORT_RST);
		chk(stack_ptr, pmr_pkg::SP_RST);
		wait_rst(1'b0);
		rd_chk(pmr_pkg::IDX_PWR_CTRL, pmr_pkg::KEEP_MASK, 2'b00);
		rd_chk(pmr_pkg::IDX_AUX_CTRL, pmr_pkg::SFR_RST, 2'b00);
		rd_chk(pmr_pkg::IDX_SER_BUF, 8'h5a, 2'b00);
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// main sequence
	initial begin
		{aclk, aresetn, s_awvalid, s_wvalid, s_bready} = '0;
		{s_arvalid, s_rready, irq_taken, rst_go, ext_req} = '0;
		{s_awaddr, s_araddr, s_wdata, s_wstrb, wake, rst_len} = '0;
		{num_errors, samples_checked, cycles} = '0;
		ce = 1'b1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_strobe();
		t_idle();
		t_pdown();
		t_reset();
		end_of_test();
	end
endmodule
`default_nettype wire
